// ===== rtl/port_status_and_iso_maps.sv
/*
  Port status and control register of downstream port 1 and the isochronous
  descriptor completion and bypass bitmaps, behind the processor register bus.
  Assumes single-cycle read and write strobes on i_clk_sys, line and attach
  levels coming from the transceiver asynchronously, and the scheduler and
  configuration logic on the same clock.
*/
`timescale 1ns/1ns
`include "port_iso_defines.svh"

module port_status_and_iso_maps
	import port_iso_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_cs,
	input wire logic i_rd_strobe,
	input wire logic i_wr_strobe,
	input wire logic [15:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_dp,
	input wire logic i_dm,
	input wire logic i_attach,
	input wire logic i_setup_done_flag,
	input wire logic i_supply_switch_capable,
	input wire logic i_indicator_capable,
	input wire logic [31:0] i_desc_done,
	input wire logic [31:0] i_desc_armed,
	input wire logic [4:0] i_current_idx,
	input wire logic i_successor_valid,
	output logic [31:0] o_rdata,
	output logic o_rdata_valid,
	output logic [3:0] o_test_select,
	output logic o_test_mode_active,
	output logic [1:0] o_indicator_select,
	output logic o_companion_handoff,
	output logic o_supply_switch_on,
	output logic o_bus_reset_active,
	output logic o_port_asleep,
	output logic o_resume_drive,
	output logic o_link_enabled,
	output logic [31:0] o_desc_process,
	output logic o_follow_successor
);

	state_type s;
	state_type next_s;
	logic power;
	logic attach;
	logic wr_port;
	logic state_wr;
	logic rd_any;
	logic rd_completion;
	logic [31:0] port_word;

	/****************************************************************
	 * Bus decode and port read word
	 ****************************************************************/
	assign power = i_supply_switch_capable ? s.supply_switch_on : 1'b1;
	assign attach = s.attach_sync[1] & power;
	assign wr_port = i_cs & i_wr_strobe & (i_addr == `ADDR_PORT_STATE);
	assign state_wr = wr_port & power;
	assign rd_any = i_cs & i_rd_strobe;
	assign rd_completion = rd_any & (i_addr == `ADDR_ISO_COMPLETION);

	// Status bits other than the line state, test select and handoff bits are gated by power here too, since the stored copies clear
	// one cycle after power drops and a read in between must still see zero.
	always_comb
	begin
		port_word = 32'h00000000;
		port_word[`BIT_TEST_HI:`BIT_TEST_LO] = s.test_select;
		port_word[`BIT_IND_HI:`BIT_IND_LO] = power ? s.indicator_select : 2'h0;
		port_word[`BIT_HANDOFF] = s.companion_handoff;
		port_word[`BIT_SUPPLY] = power;
		port_word[`BIT_LINE_DP] = s.dp_sync[1];
		port_word[`BIT_LINE_DM] = s.dm_sync[1];
		port_word[`BIT_RESET] = power & s.bus_reset_active;
		port_word[`BIT_ASLEEP] = power & s.port_asleep;
		port_word[`BIT_RESUME] = power & s.resume_drive;
		port_word[`BIT_ENABLED] = power & s.link_enabled;
		port_word[`BIT_CHANGED] = power & s.attach_changed;
		port_word[`BIT_PRESENT] = power & s.attach_present;
	end

	/****************************************************************
	 * Next state
	 ****************************************************************/
	always_comb
	begin
		next_s = s;
		next_s.dp_sync = {s.dp_sync[0], i_dp};
		next_s.dm_sync = {s.dm_sync[0], i_dm};
		next_s.attach_sync = {s.attach_sync[0], i_attach};
		next_s.setup_prev = i_setup_done_flag;

		if (!i_supply_switch_capable)
			next_s.supply_switch_on = 1'b1;
		else if (wr_port)
			next_s.supply_switch_on = i_wdata[`BIT_SUPPLY];

		if (state_wr)
			next_s.test_select = i_wdata[`BIT_TEST_HI:`BIT_TEST_LO];
		next_s.test_mode_active = (s.test_select != 4'h0);

		if (state_wr && i_indicator_capable)
			next_s.indicator_select = i_wdata[`BIT_IND_HI:`BIT_IND_LO];

		if (wr_port)
			next_s.companion_handoff = i_wdata[`BIT_HANDOFF];
		if (i_setup_done_flag && !s.setup_prev)
			next_s.companion_handoff = 1'b0;
		if (!i_setup_done_flag)
			next_s.companion_handoff = 1'b1;

		next_s.attach_present = attach;
		if (state_wr && i_wdata[`BIT_CHANGED])
			next_s.attach_changed = 1'b0;
		if (attach != s.attach_present)
			next_s.attach_changed = 1'b1;

		if (state_wr && !i_wdata[`BIT_ENABLED])
			next_s.link_enabled = 1'b0;
		// bus reset start and end; the port enables at reset end if attached.
		if (state_wr && i_wdata[`BIT_RESET])
		begin
			next_s.bus_reset_active = 1'b1;
			next_s.link_enabled = 1'b0;
		end
		else if (state_wr && s.bus_reset_active)
		begin
			next_s.bus_reset_active = 1'b0;
			next_s.link_enabled = attach;
		end

		if (state_wr && i_wdata[`BIT_ASLEEP] && s.link_enabled)
			next_s.port_asleep = 1'b1;

		// remote K-state wakes a sleeping port
		if (s.port_asleep && s.dm_sync[1] && !s.dp_sync[1] && !s.resume_drive)
			next_s.resume_drive = 1'b1;
		if (state_wr && i_wdata[`BIT_RESUME] && s.port_asleep)
			next_s.resume_drive = 1'b1;
		else if (state_wr && !i_wdata[`BIT_RESUME] && s.resume_drive)
		begin
			next_s.resume_drive = 1'b0;
			next_s.port_asleep = 1'b0;
		end

		// A detach drops the link at once; software sees it through bit 1.
		if (!attach)
		begin
			next_s.link_enabled = 1'b0;
			next_s.port_asleep = 1'b0;
			next_s.resume_drive = 1'b0;
		end

		if (!power)
		begin
			next_s.indicator_select = 2'h0;
			next_s.bus_reset_active = 1'b0;
			next_s.port_asleep = 1'b0;
			next_s.resume_drive = 1'b0;
			next_s.link_enabled = 1'b0;
			next_s.attach_changed = 1'b0;
		end

		// read clears, and completion sets win
		next_s.completion = (rd_completion ? 32'h00000000 : s.completion) | i_desc_done;

		if (i_cs && i_wr_strobe && (i_addr == `ADDR_ISO_BYPASS))
			next_s.bypass = i_wdata;
		next_s.desc_process = i_desc_armed & ~s.bypass;
		next_s.follow_successor = i_successor_valid & ~s.bypass[i_current_idx];

		next_s.rdata_valid = rd_any;
		if (rd_any)
		begin
			unique case (i_addr)
				`ADDR_PORT_STATE: next_s.rdata = port_word;
				`ADDR_ISO_COMPLETION: next_s.rdata = s.completion;
				`ADDR_ISO_BYPASS: next_s.rdata = s.bypass;
				default: next_s.rdata = 32'h00000000;
			endcase
		end
	end

	/****************************************************************
	 * State register
	 ****************************************************************/
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			s <= '0;
			s.attach_present <= 1'b0;
			s.link_enabled <= 1'b0;
			s.companion_handoff <= `RST_HANDOFF;
			s.completion <= `RST_COMPLETION;
			s.bypass <= `RST_BYPASS;
		end
		else
			s <= next_s;
	end

	assign o_rdata = s.rdata;
	assign o_rdata_valid = s.rdata_valid;
	assign o_test_select = s.test_select;
	assign o_test_mode_active = s.test_mode_active;
	assign o_indicator_select = s.indicator_select;
	assign o_companion_handoff = s.companion_handoff;
	assign o_supply_switch_on = s.supply_switch_on;
	assign o_bus_reset_active = s.bus_reset_active;
	assign o_port_asleep = s.port_asleep;
	assign o_resume_drive = s.resume_drive;
	assign o_link_enabled = s.link_enabled;
	assign o_desc_process = s.desc_process;
	assign o_follow_successor = s.follow_successor;

	/****************************************************************
	 * Assertions
	 ****************************************************************/
	a_handoff_forced: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		!i_setup_done_flag |=> o_companion_handoff)
		else $error("handoff not forced while unconfigured");

	a_handoff_cleared: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(i_setup_done_flag && !s.setup_prev) |=> !o_companion_handoff)
		else $error("handoff not cleared on setup rise");

	a_unpowered_frozen: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(wr_port && !power) |=> $stable(o_test_select) && !o_bus_reset_active)
		else $error("port state changed while unpowered");

	a_indicator_ignored: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(state_wr && !i_indicator_capable) |=> $stable(o_indicator_select))
		else $error("indicator written without capability");

	a_test_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		state_wr ##2 1'b1
		|-> o_test_mode_active == ($past(i_wdata[`BIT_TEST_HI:`BIT_TEST_LO], 2) != 4'h0))
		else $error("test mode flag mismatch");

	a_reset_disables: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(state_wr && i_wdata[`BIT_RESET]) |=> o_bus_reset_active && !o_link_enabled)
		else $error("bus reset did not start or enable stayed");

	a_unpowered_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(rd_any && i_addr == `ADDR_PORT_STATE && !power)
		|=> (o_rdata[`BIT_IND_HI:`BIT_IND_LO] == 2'h0)
		&& (o_rdata[`BIT_RESET:`BIT_RESUME] == 3'h0)
		&& (o_rdata[`BIT_ENABLED:`BIT_PRESENT] == 3'h0))
		else $error("status bits nonzero while unpowered");

	a_done_kept: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(|i_desc_done) |=> (s.completion & $past(i_desc_done)) == $past(i_desc_done))
		else $error("completion lost");

	a_read_clears: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(rd_completion && i_desc_done == 32'h00000000) |=> s.completion == 32'h00000000)
		else $error("completion not cleared by read");

	a_bypass_skips: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		1'b1 |=> (o_desc_process & $past(s.bypass)) == 32'h00000000)
		else $error("bypassed descriptor processed");

	a_successor_ignored: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		s.bypass[i_current_idx] |=> !o_follow_successor)
		else $error("bypassed successor followed");

	// The checks below, except a_line_levels, watch stored state rather than the read word, because the read
	// path gates by power and would hide a wrong update while the port is unpowered.
	// A failure in those therefore points at the update logic, not at the read mux.

	a_line_levels: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(rd_any && i_addr == `ADDR_PORT_STATE)
		|=> o_rdata[`BIT_LINE_DP:`BIT_LINE_DM] == $past({s.dp_sync[1], s.dm_sync[1]}))
		else $error("line state bits do not follow the lines");

	a_change_flagged: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(power && s.attach_sync[1] != s.attach_present) |=> s.attach_changed)
		else $error("attach change not flagged");

	a_present_follows: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		power |=> s.attach_present == $past(s.attach_sync[1]))
		else $error("attach present does not follow the attach level");

	a_resume_on_k: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(power && attach && s.port_asleep && s.dm_sync[1] && !s.dp_sync[1] && !state_wr)
		|=> o_resume_drive)
		else $error("resume not shown for a remote K-state");

	a_detached_disabled: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		!attach |=> !o_link_enabled)
		else $error("port enabled with nothing attached");

	a_bus_reset_ends: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(state_wr && !i_wdata[`BIT_RESET] && s.bus_reset_active) |=> !o_bus_reset_active)
		else $error("bus reset did not end");

	a_supply_fixed: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		!i_supply_switch_capable |=> o_supply_switch_on)
		else $error("supply bit not held on without switching capability");

endmodule

// ===== inc/port_iso_defines.svh
/*
  Offsets, field positions and reset values of the port status register and the
  isochronous descriptor bitmaps. Assumes byte addresses on the processor bus.
*/
`ifndef PORT_ISO_DEFINES_SVH
`define PORT_ISO_DEFINES_SVH

`define ADDR_PORT_STATE 16'h0064
`define ADDR_ISO_COMPLETION 16'h0130
`define ADDR_ISO_BYPASS 16'h0134

`define BIT_TEST_HI 19
`define BIT_TEST_LO 16
`define BIT_IND_HI 15
`define BIT_IND_LO 14
`define BIT_HANDOFF 13
`define BIT_SUPPLY 12
`define BIT_RESET 8
`define BIT_ASLEEP 7
`define BIT_RESUME 6
`define BIT_ENABLED 2
`define BIT_CHANGED 1
`define BIT_LINE_DP 11
`define BIT_LINE_DM 10
`define BIT_PRESENT 0

`define RST_COMPLETION 32'h00000000
`define RST_BYPASS 32'hffffffff
`define RST_HANDOFF 1'h1

`endif

// ===== inc/port_iso_pkg.sv
/*
  Types of the port status and isochronous bitmap block.
  Assumes port_iso_defines.svh is compiled alongside.
*/
package port_iso_pkg;

	typedef struct packed {
		logic [1:0] dp_sync;
		logic [1:0] dm_sync;
		logic [1:0] attach_sync;
		logic setup_prev;
		logic [3:0] test_select;
		logic [1:0] indicator_select;
		logic companion_handoff;
		logic supply_switch_on;
		logic bus_reset_active;
		logic port_asleep;
		logic resume_drive;
		logic link_enabled;
		logic attach_changed;
		logic attach_present;
		logic test_mode_active;
		logic [31:0] completion;
		logic [31:0] bypass;
		logic [31:0] desc_process;
		logic follow_successor;
		logic [31:0] rdata;
		logic rdata_valid;
	} state_type;

endpackage

// ===== testbench/usb_device_model.sv
/*
  Behavioural downstream device on port 1: attach level and data lines.
  Assumes host-side pull-downs, so a detached port shows both lines low.
*/
`timescale 1ns/1ns
module usb_device_model
(
	input wire logic i_plug,
	input wire logic i_k,
	output logic o_dp,
	output logic o_dm,
	output logic o_attach
);
	// ****************
	// Line levels
	// ****************
	// Idle is J (dp high); a resume request drives K (dm high).
	assign o_attach = i_plug;
	assign o_dp = i_plug & ~i_k;
	assign o_dm = i_plug & i_k;
endmodule

// ===== testbench/tb.sv
/*
  Self-checking bench for the port status and isochronous bitmap block.
  Assumes a 25 MHz clock and a device model on the port lines.
*/
`timescale 1ns/1ns
module tb;
	logic i_clk_sys = 0, i_rstn = 0, i_cs = 0, i_rd_strobe = 0, i_wr_strobe = 0;
	logic i_setup_done_flag = 0, i_supply_switch_capable = 1, i_indicator_capable = 0;
	logic i_successor_valid = 0, plug = 0, kreq = 0, i_dp, i_dm, i_attach;
	logic [15:0] i_addr = 16'h0000;
	logic [31:0] i_wdata = 32'h0, i_desc_done = 32'h0, i_desc_armed = 32'h0;
	logic [31:0] exp_done = 32'h0, bw;
	logic [4:0] i_current_idx = 5'h00;
	logic [31:0] o_rdata, o_desc_process;
	logic o_rdata_valid, o_test_mode_active, o_companion_handoff, o_supply_switch_on;
	logic o_bus_reset_active, o_port_asleep, o_resume_drive, o_link_enabled;
	logic o_follow_successor;
	logic [3:0] o_test_select;
	logic [1:0] o_indicator_select;
	int n_mismatch = 0, tests_run = 0, seed = 26470;

	port_status_and_iso_maps port_status_and_iso_maps_inst (.i_clk_sys, .i_rstn, .i_cs,
		.i_rd_strobe, .i_wr_strobe, .i_addr, .i_wdata, .i_dp, .i_dm, .i_attach,
		.i_setup_done_flag, .i_supply_switch_capable, .i_indicator_capable, .i_desc_done,
		.i_desc_armed, .i_current_idx, .i_successor_valid, .o_rdata, .o_rdata_valid,
		.o_test_select, .o_test_mode_active, .o_indicator_select, .o_companion_handoff,
		.o_supply_switch_on, .o_bus_reset_active, .o_port_asleep, .o_resume_drive,
		.o_link_enabled, .o_desc_process, .o_follow_successor);
	usb_device_model usb_device_model_inst (.i_plug(plug), .i_k(kreq), .o_dp(i_dp),
		.o_dm(i_dm), .o_attach(i_attach));

	always #20 i_clk_sys = ~i_clk_sys;

	// ****************
	// Tasks
	// ****************
	task tick(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			n_mismatch++;
		end
	endtask

	task wr(input logic [15:0] a, input logic [31:0] d);
		i_cs = 1;
		i_wr_strobe = 1;
		i_addr = a;
		i_wdata = d;
		tick(1);
		i_cs = 0;
		i_wr_strobe = 0;
		tick(1);
	endtask

	// The done pulse rides along with the strobe to hit the clearing read.
	task rd(input logic [15:0] a, input logic [31:0] e, input logic [31:0] d);
		i_cs = 1;
		i_rd_strobe = 1;
		i_addr = a;
		i_desc_done = d;
		tick(1);
		i_cs = 0;
		i_rd_strobe = 0;
		i_desc_done = 0;
		chk({31'h0, o_rdata_valid}, 32'h1);
		chk(o_rdata, e);
		tick(1);
	endtask

	task wrap_up;
		$display("Mismatches %0d of %0d checks", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		repeat (8000) @(posedge i_clk_sys);
		n_mismatch++;
		wrap_up;
	end

	// ****************
	// Main sequence
	// ****************
	initial
	begin
		tick(4);
		i_rstn = 1;
		tick(3);
		rd(16'h0064, 32'h00002000, 0);
		rd(16'h0134, 32'hffffffff, 0);
		wr(16'h0064, 32'h00002104);
		chk({30'h0, o_bus_reset_active, o_link_enabled}, 32'h0);
		wr(16'h0064, 32'h00003000);
		plug = 1;
		tick(4);
		rd(16'h0064, 32'h00003803, 0);
		i_setup_done_flag = 1;
		tick(2);
		chk({31'h0, o_companion_handoff}, 0);
		wr(16'h0064, 32'h00001102);
		rd(16'h0064, 32'h00001901, 0);
		wr(16'h0064, 32'h00001000);
		rd(16'h0064, 32'h00001805, 0);
		wr(16'h0064, 32'h00001084);
		kreq = 1;
		tick(4);
		rd(16'h0064, 32'h000014c5, 0);
		chk({30'h0, o_port_asleep, o_resume_drive}, 32'h3);
		kreq = 0;
		wr(16'h0064, 32'h00001004);
		rd(16'h0064, 32'h00001805, 0);
		wr(16'h0064, 32'h0000d004);
		chk({30'h0, o_indicator_select}, 0);
		i_indicator_capable = 1;
		wr(16'h0064, 32'h0000d004);
		rd(16'h0064, 32'h0000d805, 0);
		for (int t = 0; t < 16; t++)
		begin
			wr(16'h0064, {12'h000, t[3:0], 16'hd004});
			chk({28'h0, o_test_select}, t);
			chk({31'h0, o_test_mode_active}, {31'h0, t != 0});
		end
		wr(16'h0064, 32'h00000004);
		rd(16'h0064, 32'h00000800, 0);
		rd(16'h0068, 32'h00000000, 0);
		for (int i = 0; i < 24; i++)
		begin
			bw = $random(seed) & $random(seed) & $random(seed);
			if (i % 6 == 5)
			begin
				rd(16'h0130, exp_done, bw);
				exp_done = bw;
			end
			else
			begin
				i_desc_done = bw;
				exp_done |= bw;
				tick(1);
				i_desc_done = 0;
				tick(1);
			end
		end
		rd(16'h0130, exp_done, 0);
		rd(16'h0130, 32'h0, 0);
		for (int i = 0; i < 8; i++)
		begin
			bw = $random(seed);
			i_desc_armed = $random(seed);
			i_current_idx = i_desc_armed[4:0];
			i_successor_valid = i_desc_armed[5];
			if (i % 2 == 0)
				bw[i_current_idx] = 1'b0;
			wr(16'h0134, bw);
			rd(16'h0134, bw, 0);
			chk(o_desc_process, i_desc_armed & ~bw);
			chk({31'h0, o_follow_successor}, {31'h0, i_successor_valid & ~bw[i_current_idx]});
		end
		i_supply_switch_capable = 0;
		tick(2);
		chk({31'h0, o_supply_switch_on}, 32'h1);
		i_setup_done_flag = 0;
		tick(2);
		chk({31'h0, o_companion_handoff}, 32'h1);
		i_supply_switch_capable = 1;
		plug = 0;
		i_rstn = 0;
		tick(2);
		i_rstn = 1;
		tick(3);
		rd(16'h0064, 32'h00002000, 0);
		rd(16'h0134, 32'hffffffff, 0);
		wrap_up;
	end
endmodule
